/* verilog/spi_port_regs.vh */
// constants for the serial port data path: field positions, reset values, timing counts
// assumes a 25 MHz core clock and an outside peer sharing the serial clock
`ifndef SPI_PORT_REGS_VH
`define SPI_PORT_REGS_VH

// data widths
`define SPI_DATA_W        8
`define SPI_BITS_PER_BYTE 4'h7
`define SPI_BITCNT_W      4

// field positions inside the shift register
`define SPI_MSB_POS       7
`define SPI_NEXT_MSB_POS  6

// reset values
`define SPI_BYTE_RST      8'h00
`define SPI_BITCNT_RST    4'h0
`define SPI_DIV_RST       8'h00

// master serial clock: half period in ns and derived core cycles (40 ns clock)
`define SPI_CORE_PERIOD_NS 40
`define SPI_HALF_PERIOD_NS 160
`define SPI_HALF_CYC      ((`SPI_HALF_PERIOD_NS + `SPI_CORE_PERIOD_NS - 1) / `SPI_CORE_PERIOD_NS)

// receive fifo shape
`define SPI_FIFO_DEPTH    16
`define SPI_FIFO_AW       4

`endif

/* verilog/spi_rx_fifo.v */
// flip-flop fifo for received bytes, width and depth as parameters
// assumes one clock, asynchronous active high reset, depth a power of two
module spi_rx_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rst,
  // filling side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // draining side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1]; // storage words
  reg [AW-1:0]    wr_ptr_reg;          // write index
  reg [AW-1:0]    rd_ptr_reg;          // read index
  reg [AW:0]      count_reg;           // words held
  wire            push;                // word accepted
  wire            pop;                 // word removed

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage write, no reset needed on data
  always @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and occupancy
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // spi_rx_fifo

/* verilog/spi_port_buffer_and_enable.v */
// serial port data path: shift register, receive fifo, holding buffer, flags, pins
// assumes software strobes on core_clk; link pins arrive asynchronously
// assumes a fixed link mode: clock idles low, sample on rise, change on fall
// assumes direction and pin setup bits come from software on core_clk
`include "spi_port_regs.vh"

module spi_port_buffer_and_enable (
  // clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // software control bits
  input  wire       port_enable_bit,
  input  wire       master_mode,
  // software holding buffer access
  input  wire       buf_wr_en,
  input  wire [7:0] buf_wr_data,
  input  wire       buf_rd_en,
  output reg  [7:0] serial_holding_buffer,
  // status and flag clears
  input  wire       irq_flag_clr,
  input  wire       collision_flag_clr,
  output reg        buffer_full_flag,
  output reg        port_irq_flag,
  output reg        write_collision_flag,
  output reg        overflow_flag,
  output reg        busy_flag,
  output reg        pins_assigned,
  // direction and pin configuration bits
  input  wire       portc_dir_sdo,
  input  wire       portc_dir_sck,
  input  wire       porta_dir_ss,
  input  wire       porta_pin5_digital,
  // serial pins
  input  wire       sdi_in,
  input  wire       sck_in,
  output reg        sck_out,
  output reg        sck_oe,
  output reg        sdo_out,
  output reg        sdo_oe,
  input  wire       ss_n_in
);

  // each link pin passes two flops before any logic looks at it
  // synchronisers for pins from outside the clock domain
  reg       sck_meta_reg;    // first stage, read only by second
  reg       sck_sync_reg;    // synced serial clock
  reg       sck_prev_reg;    // previous synced clock for edges
  reg       sdi_meta_reg;    // first stage
  reg       sdi_sync_reg;    // synced data in
  reg       ss_meta_reg;     // first stage
  reg       ss_sync_reg;     // synced slave select, low active

  // shift engine state
  // software writes load the shifter directly, reads come through the holding buffer
  reg [7:0] serial_shift_reg;
  reg       sample_reg;       // bit caught on rising edge
  reg [3:0] bit_cnt_reg;      // bits completed in this byte
  reg       active_reg;       // transfer in progress
  reg [7:0] div_reg;          // master half period counter
  reg       msck_reg;         // internal master clock level

  // fifo connections
  // the fifo sits between the shifter and the holding buffer
  reg       push_valid_reg;   // byte ready for fifo
  reg [7:0] push_data_reg;    // byte to fifo
  wire      fifo_in_ready;    // fifo has room
  wire      fifo_out_valid;   // fifo holds a byte
  wire [7:0] fifo_out_data;   // oldest byte
  wire      fifo_pop;         // moving a byte to holding buffer

  // decoded conditions
  // all combinational, read by the clocked processes below
  wire      ss_usable;        // slave select routed to port
  wire      ss_active;        // slave selected
  wire      sck_usable;       // slave clock routed to port
  wire      rise_evt;         // serial clock rising
  wire      fall_evt;         // serial clock falling
  wire      start_ok;         // idle write may start
  wire      last_bit;         // this falling edge ends the byte
  wire [7:0] shifted;         // shift register after one step

  // true when pin function survives the direction bit
  // shared by every pin whose direction bit may override the port
  function pin_kept;
    input dir_bit;
    input wanted;
    begin
      pin_kept = (dir_bit == wanted);
    end
  endfunction

  // slave select counts only with its pin set up as a digital input
  assign ss_usable  = pin_kept(porta_dir_ss, 1'b1) & porta_pin5_digital;
  // select line is low active after the synchroniser
  assign ss_active  = ss_usable & ~ss_sync_reg;
  // slave clock taken only with its direction bit set
  assign sck_usable = pin_kept(portc_dir_sck, 1'b1);
  // master edges come from the divider, one cycle before the pin moves
  // slave edges come from the synced pin and its previous level
  assign rise_evt   = master_mode ? (div_reg == (`SPI_HALF_CYC - 1) && ~msck_reg && active_reg)
                                  : (sck_usable & ss_active & sck_sync_reg & ~sck_prev_reg);
  assign fall_evt   = master_mode ? (div_reg == (`SPI_HALF_CYC - 1) && msck_reg && active_reg)
                                  : (sck_usable & ss_active & ~sck_sync_reg & sck_prev_reg);
  // count of seven: this falling edge is the eighth
  assign last_bit   = (bit_cnt_reg == `SPI_BITS_PER_BYTE);
  // msb leaves first, new bit enters at the bottom
  assign shifted    = {serial_shift_reg[`SPI_NEXT_MSB_POS:0], sample_reg};
  // fifo room is demanded before starting, but a push still pending is not counted, so a finished master byte can be lost
  assign start_ok   = ~active_reg & fifo_in_ready & (bit_cnt_reg == `SPI_BITCNT_RST);
  // buffer refills from the fifo once software has emptied it
  assign fifo_pop   = fifo_out_valid & ~buffer_full_flag;

  // two flip-flop synchronisers and edge history
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // idle levels: clock low, select high, so no false edge follows reset
      sck_meta_reg <= 1'b0;
      sck_sync_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
      sdi_meta_reg <= 1'b0;
      sdi_sync_reg <= 1'b0;
      ss_meta_reg  <= 1'b1;
      ss_sync_reg  <= 1'b1;
    end else begin
      // first stage feeds only the second
      sck_meta_reg <= sck_in;
      sck_sync_reg <= sck_meta_reg;
      sck_prev_reg <= sck_sync_reg;
      sdi_meta_reg <= sdi_in;
      sdi_sync_reg <= sdi_meta_reg;
      ss_meta_reg  <= ss_n_in;
      ss_sync_reg  <= ss_meta_reg;
    end
  end

  // master clock divider, runs only during a master transfer
  // rising edge ends the first half period, falling edge the second
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_reg  <= `SPI_DIV_RST;
      msck_reg <= 1'b0;
    end else if (~port_enable_bit | ~master_mode | ~active_reg) begin
      // idle level low, counter parked
      div_reg  <= `SPI_DIV_RST;
      msck_reg <= 1'b0;
    end else if (div_reg == (`SPI_HALF_CYC - 1)) begin
      // half period over, toggle clock
      div_reg  <= `SPI_DIV_RST;
      msck_reg <= ~msck_reg;
    end else begin
      // still inside the half period
      div_reg <= div_reg + 8'h01;
    end
  end

  // shift engine and byte completion
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // shifter empty, no byte pending
      serial_shift_reg <= `SPI_BYTE_RST;
      sample_reg       <= 1'b0;
      bit_cnt_reg      <= `SPI_BITCNT_RST;
      active_reg       <= 1'b0;
      push_valid_reg   <= 1'b0;
      push_data_reg    <= `SPI_BYTE_RST;
    end else begin
      // push strobe lasts a single cycle
      push_valid_reg <= 1'b0;
      if (~port_enable_bit) begin
        // disabled: engine held idle until enabled again
        // flags other than busy_flag and pins_assigned, and fifo contents, survive a disable
        bit_cnt_reg <= `SPI_BITCNT_RST;
        active_reg  <= 1'b0;
      end else if (buf_wr_en & start_ok) begin
        // idle write goes straight to the shifter
        serial_shift_reg <= buf_wr_data;
        // master starts now, slave waits for the outside clock
        active_reg       <= master_mode;
      end else begin
        if (~master_mode & ~ss_active) begin
          // slave deselected: partial byte abandoned
          bit_cnt_reg <= `SPI_BITCNT_RST;
        end
        if (rise_evt) begin
          // catch incoming bit
          sample_reg <= sdi_sync_reg;
          if (~master_mode) begin
            // slave is busy from its first clock edge
            active_reg <= 1'b1;
          end
        end
        if (fall_evt) begin
          // one bit moves on each falling edge
          serial_shift_reg <= shifted;
          if (last_bit) begin
            // whole byte received, hand to fifo
            bit_cnt_reg    <= `SPI_BITCNT_RST;
            active_reg     <= 1'b0;
            push_valid_reg <= 1'b1;
            push_data_reg  <= shifted;
          end else begin
            // more bits to come
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
      end
    end
  end

  // received bytes queue here so shifting continues while software is slow
  // a push is refused only when all sixteen words are taken
  spi_rx_fifo #(
    .WIDTH (`SPI_DATA_W),
    .DEPTH (`SPI_FIFO_DEPTH),
    .AW    (`SPI_FIFO_AW)
  ) rx_fifo_inst (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (push_valid_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data_reg),
    .out_valid (fifo_out_valid),
    .out_ready (~buffer_full_flag),
    .out_data  (fifo_out_data)
  );

  // holding buffer, buffer full and interrupt flag
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // buffer empty and flags low in reset
      serial_holding_buffer <= `SPI_BYTE_RST;
      buffer_full_flag      <= 1'b0;
      port_irq_flag         <= 1'b0;
    end else begin
      if (fifo_pop) begin
        // next received byte lands in the buffer
        // only while empty, so an unread byte is never overwritten
        serial_holding_buffer <= fifo_out_data;
        buffer_full_flag      <= 1'b1;
      end else if (buf_rd_en) begin
        // software read empties the buffer
        buffer_full_flag <= 1'b0;
      end
      if (fifo_pop) begin
        // set beats a simultaneous clear
        port_irq_flag <= 1'b1;
      end else if (irq_flag_clr) begin
        // software clear of the interrupt flag
        port_irq_flag <= 1'b0;
      end
    end
  end

  // collision, overflow and busy status
  // writes while disabled are ignored without a flag
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      write_collision_flag <= 1'b0;
      overflow_flag        <= 1'b0;
      busy_flag            <= 1'b0;
    end else begin
      if (buf_wr_en & port_enable_bit & ~start_ok) begin
        // refused: transfer running or fifo full
        // write dropped, only software clears this
        write_collision_flag <= 1'b1;
      end else if (collision_flag_clr) begin
        write_collision_flag <= 1'b0;
      end
      if (push_valid_reg & ~fifo_in_ready) begin
        // master or slave byte lost with fifo full
        overflow_flag <= 1'b1;
      end else if (collision_flag_clr) begin
        overflow_flag <= 1'b0;
      end
      // busy follows the engine one cycle late
      busy_flag <= active_reg | (bit_cnt_reg != `SPI_BITCNT_RST);
    end
  end

  // pin drivers, each gated by enable and its direction bit
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // all pins released in reset
      sck_out       <= 1'b0;
      sck_oe        <= 1'b0;
      sdo_out       <= 1'b0;
      sdo_oe        <= 1'b0;
      pins_assigned <= 1'b0;
    end else begin
      // pin ownership follows the enable bit
      pins_assigned <= port_enable_bit;
      // clock level mirrors the divider, low when idle
      sck_out       <= msck_reg;
      // master drives clock only with direction cleared
      sck_oe  <= port_enable_bit & master_mode & pin_kept(portc_dir_sck, 1'b0);
      // top bit of the shifter always sits on the data line
      sdo_out <= serial_shift_reg[`SPI_MSB_POS];
      // data out needs direction cleared; slave drives only when selected
      sdo_oe  <= port_enable_bit & pin_kept(portc_dir_sdo, 1'b0)
                 & (master_mode | ss_active);
    end
  end

endmodule // spi_port_buffer_and_enable

/* tb/spi_port_checker.sv */
// checker of the serial port data path, attached to the top module by bind
// assumes one core_clk domain with asynchronous active high rst
module spi_port_checker (
  // clock and reset
  input wire       core_clk,
  input wire       rst,
  // software side
  input wire       port_enable_bit,
  input wire       master_mode,
  input wire       buf_wr_en,
  input wire [7:0] buf_wr_data,
  input wire       buf_rd_en,
  input wire [7:0] serial_holding_buffer,
  input wire       irq_flag_clr,
  input wire       collision_flag_clr,
  // flags
  input wire       buffer_full_flag,
  input wire       port_irq_flag,
  input wire       write_collision_flag,
  input wire       busy_flag,
  input wire       pins_assigned,
  // pins and directions
  input wire       portc_dir_sdo,
  input wire       portc_dir_sck,
  input wire       sck_oe,
  input wire       sdo_out,
  input wire       sdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // a read of a full buffer empties it
  property p_rd_clr; buf_rd_en && buffer_full_flag |=> !buffer_full_flag; endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("full flag kept after read");
  // buffer load raises the interrupt flag too
  property p_full_irq; $rose(buffer_full_flag) |-> port_irq_flag; endproperty
  a_full_irq: assert property (p_full_irq) else $error("no irq with full");
  // unread byte is not overwritten by the next one
  property p_hold; buffer_full_flag && $past(buffer_full_flag) |-> $stable(serial_holding_buffer); endproperty
  a_hold: assert property (p_hold) else $error("unread byte overwritten");
  // second write in a row lands in a running transfer
  property p_write_collision_flag; buf_wr_en && port_enable_bit && master_mode ##1 buf_wr_en && master_mode
    |=> write_collision_flag; endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");
  // hardware never drops the collision flag by itself
  property p_write_collision_flag_keep; write_collision_flag && !collision_flag_clr |=> write_collision_flag; endproperty
  a_write_collision_flag_keep: assert property (p_write_collision_flag_keep) else $error("collision flag lost");
  // interrupt flag sticky until cleared
  property p_irq_keep; port_irq_flag && !irq_flag_clr |=> port_irq_flag; endproperty
  a_irq_keep: assert property (p_irq_keep) else $error("irq flag lost");
  // master start comes from a write and shows its top bit first
  property p_first; master_mode && $rose(busy_flag) |-> $past(buf_wr_en, 2)
    && sdo_out == $past(buf_wr_data[7], 2); endproperty
  a_first: assert property (p_first) else $error("start without write");
  // disabled port lets go of its pins
  property p_dis; !port_enable_bit [*2] |-> !pins_assigned && !sdo_oe && !sck_oe; endproperty
  a_dis: assert property (p_dis) else $error("pins held while disabled");
  // enabled port takes its pins
  property p_en; port_enable_bit [*2] |-> pins_assigned; endproperty
  a_en: assert property (p_en) else $error("pins not assigned");
  // direction bits override the pin drivers
  property p_sdo_ovr; portc_dir_sdo [*2] |-> !sdo_oe; endproperty
  a_sdo_ovr: assert property (p_sdo_ovr) else $error("sdo drives against direction");
  property p_sck_ovr; (portc_dir_sck || !master_mode) [*2] |-> !sck_oe; endproperty
  a_sck_ovr: assert property (p_sck_ovr) else $error("sck drives against direction");
endmodule // spi_port_checker

bind spi_port_buffer_and_enable spi_port_checker u_chk (.*);

/* tb/spi_peer_model.sv */
// outside serial peer: slave to the device's clock, or master with its own
// assumes idle-low clock, take on rising edge, change on falling edge
module spi_peer_model (
  // lines seen from the device
  input wire logic dut_sck,
  input wire logic dut_sdo,
  input wire logic master_mode,
  // lines the peer drives
  output logic     sdi,
  output logic     sck,
  output logic     ss_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx; // byte being sent
  logic [7:0] rx; // bits taken in, newest at bit 0
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    tx = 8'hA5;
    sdi = 1'b1;
    rx = 8'h00;
  end
  // take the device's bit on its rising clock
  always @(posedge dut_sck) if (master_mode) rx <= {rx[6:0], dut_sdo};
  // move on falling clock; past the byte the line keeps changing
  always @(negedge dut_sck) if (master_mode) begin
    tx = {tx[6:0], ~tx[0]};
    sdi = tx[7];
  end
  // preload the byte to answer with
  task load(input logic [7:0] b);
    tx = b;
    sdi = b[7];
  endtask
  // peer as master: 320 ns clock only inside the frame
  task automatic xfer(input logic [7:0] b);
    integer i;
    #7 ss_n = 1'b0;
    for (i = 7; i >= 0; i--) begin
      sdi = b[i];
      #160 sck = 1'b1;
      rx = {rx[6:0], dut_sdo};
      #160 sck = 1'b0;
    end
    #160 ss_n = 1'b1;
    sdi = ~sdi;
  endtask
endmodule // spi_peer_model

/* tb/spi_port_buffer_and_enable_tb.sv */
// self-checking bench of the serial port data path with an outside peer
// assumes 25 MHz core clock; inputs change on the falling edge
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module spi_port_buffer_and_enable_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, port_enable_bit, master_mode, buf_wr_en, buf_rd_en;
  logic irq_flag_clr, collision_flag_clr, portc_dir_sdo, portc_dir_sck;
  logic porta_dir_ss, porta_pin5_digital, sdi_in, peer_sck, ss_n_in;
  logic [7:0] buf_wr_data, serial_holding_buffer, b, b2;
  logic buffer_full_flag, port_irq_flag, write_collision_flag, overflow_flag;
  logic busy_flag, pins_assigned, sck_out, sck_oe, sdo_out, sdo_oe;
  integer n_fail = 0, cmp_count = 0, cyc = 0, k, i;
  wire sck_line = sck_oe ? sck_out : peer_sck; // peer clock idles low
  wire sdo_line = sdo_oe ? sdo_out : ~sdo_out; // released line shows inverse
  spi_port_buffer_and_enable dut (.*, .sck_in(sck_line));
  spi_peer_model peer (.dut_sck(sck_line), .dut_sdo(sdo_line), .master_mode(master_mode),
    .sdi(sdi_in), .sck(peer_sck), .ss_n(ss_n_in));
  // core clock 40 ns
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report;
    end
  end
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one-cycle write strobe
  task pulse_wr(input logic [7:0] d);
    @(negedge core_clk) buf_wr_data = d;
    buf_wr_en = 1'b1;
    @(negedge core_clk) buf_wr_en = 1'b0;
  endtask
  task wait_full;
    for (k = 0; k < 400 && buffer_full_flag !== 1'b1; k++) @(negedge core_clk);
  endtask
  // wait for a byte, compare, read it and clear the interrupt
  task rd_check(input logic [7:0] e);
    wait_full;
    `CHK(port_irq_flag, 1'b1)
    `CHK(serial_holding_buffer, e)
    buf_rd_en = 1'b1;
    irq_flag_clr = 1'b1;
    @(negedge core_clk) buf_rd_en = 1'b0;
    irq_flag_clr = 1'b0;
    `CHK({buffer_full_flag, port_irq_flag}, 2'b00)
  endtask
  initial begin
    {rst, port_enable_bit, master_mode, buf_wr_en, buf_rd_en, irq_flag_clr} = 6'h20;
    {collision_flag_clr, portc_dir_sdo, portc_dir_sck, porta_dir_ss, porta_pin5_digital} = 5'h0F;
    buf_wr_data = 8'h00;
    void'($urandom(87));
    repeat (3) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK({serial_holding_buffer, buffer_full_flag, write_collision_flag}, 10'h000)
    // master, pins handed to the port
    master_mode = 1'b1;
    portc_dir_sdo = 1'b0;
    portc_dir_sck = 1'b0;
    port_enable_bit = 1'b1;
    repeat (3) @(negedge core_clk);
    // corner bytes then random ones, read before each next write
    for (i = 0; i < 8; i++) begin
      b = (i == 0) ? 8'h80 : (i == 1) ? 8'hFF : 8'($urandom);
      b2 = (i == 0) ? 8'h01 : (i == 1) ? 8'h00 : 8'($urandom);
      peer.load(b2);
      pulse_wr(b);
      rd_check(b2);
      `CHK(peer.rx, b)
    end
    // back-to-back write: the second one is dropped
    b = 8'($urandom);
    b2 = 8'($urandom);
    peer.load(b2);
    buf_wr_data = b;
    buf_wr_en = 1'b1;
    @(negedge core_clk) buf_wr_data = ~b;
    @(negedge core_clk) buf_wr_en = 1'b0;
    `CHK(write_collision_flag, 1'b1)
    rd_check(b2);
    `CHK(peer.rx, b)
    collision_flag_clr = 1'b1;
    @(negedge core_clk) collision_flag_clr = 1'b0;
    `CHK(write_collision_flag, 1'b0)
    // second byte arrives while the first is unread
    peer.load(b);
    pulse_wr(b2);
    wait_full;
    peer.load(~b);
    pulse_wr(~b2);
    // let the second byte land in the fifo behind the unread one
    repeat (80) @(negedge core_clk);
    rd_check(b);
    rd_check(~b);
    // disable: writes ignored, pins released, then reconfigure as slave
    port_enable_bit = 1'b0;
    pulse_wr(8'h3C);
    repeat (2) @(negedge core_clk);
    `CHK({write_collision_flag, busy_flag, pins_assigned, sdo_oe, sck_oe}, 5'h00)
    master_mode = 1'b0;
    portc_dir_sck = 1'b1;
    port_enable_bit = 1'b1;
    for (i = 0; i < 4; i++) begin
      b = (i == 0) ? 8'h01 : 8'($urandom);
      b2 = (i == 0) ? 8'h80 : 8'($urandom);
      repeat (2) @(negedge core_clk);
      pulse_wr(b);
      peer.xfer(b2);
      `CHK(peer.rx, b)
      rd_check(b2);
    end
    // unread slave bytes pile up: buffer and 16 fifo words hold, one more is lost
    for (i = 0; i < 18; i++) peer.xfer(8'(i));
    repeat (4) @(negedge core_clk);
    `CHK(overflow_flag, 1'b1)
    for (i = 0; i < 17; i++) rd_check(8'(i));
    collision_flag_clr = 1'b1;
    @(negedge core_clk) collision_flag_clr = 1'b0;
    `CHK(overflow_flag, 1'b0)
    // slave select pin not set up as digital: frame ignored
    porta_pin5_digital = 1'b0;
    peer.xfer(8'h96);
    repeat (8) @(negedge core_clk);
    `CHK({buffer_full_flag, sdo_oe}, 2'b00)
    porta_pin5_digital = 1'b1;
    // direction bit set: data output let go
    portc_dir_sdo = 1'b1;
    repeat (3) @(negedge core_clk);
    `CHK(sdo_oe, 1'b0)
    final_report;
  end
endmodule // spi_port_buffer_and_enable_tb
